/* core/ebpoc_pkg.sv */
// shared constants and types of the enhanced bridge output stage
package ebpoc_pkg;

  // register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_SHDN = 8'h04;
  localparam logic [7:0] ADDR_DBND = 8'h08;
  localparam logic [7:0] ADDR_STEER = 8'h0c;
  localparam logic [7:0] ADDR_STAT = 8'h10;

  // field positions
  localparam int CTRL_CFG_LSB = 6;
  localparam int CTRL_MODE_LSB = 0;
  localparam int SHDN_STATUS_BIT = 7;
  localparam int SHDN_SRC_LSB = 4;
  localparam int SHDN_AC_LSB = 2;
  localparam int SHDN_BD_LSB = 0;
  localparam int DBND_AUTO_BIT = 7;
  localparam int DBND_DLY_LSB = 0;
  localparam int STEER_SYNC_BIT = 4;
  localparam int STEER_EN_LSB = 0;
  localparam int SRC_INT_BIT = 0;
  localparam int SRC_CMP_BIT = 1;

  // reset values
  localparam logic [3:0] MODE_RST = 4'h0;
  localparam logic [2:0] SRC_RST = 3'h0;
  localparam logic [1:0] SAFE_RST = 2'h0;
  localparam logic [6:0] DLY_RST = 7'h00;
  localparam logic [3:0] STEER_RST = 4'h1;

  localparam logic [1:0] MODE_PWM = 2'h3;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  // pair safe state: bit 1 high floats the pair, else bit 0 is driven
  localparam int SAFE_TRI_BIT = 1;

  // timing
  localparam int DIR_LEAD_COUNTS = 4;
  localparam int TCY_IN_TOSC = 4;
  localparam int TOSC_PS = 5000;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int CLKS_PER_TCY = TCY_IN_TOSC * TOSC_PS / CLK_PERIOD_PS;
  localparam int DB_CNT_W = 12;

  typedef enum logic [1:0] {
    CFG_SINGLE = 2'h0,
    CFG_FWD = 2'h1,
    CFG_HALF = 2'h2,
    CFG_REV = 2'h3
  } ebpoc_cfg_t;

  typedef enum logic [3:0] {
    ST_OFF = 4'h1,
    ST_RUN = 4'h2,
    ST_SHUT = 4'h4,
    ST_RESTART = 4'h8
  } ebpoc_state_t;

  typedef struct packed {
    logic a;
    logic b;
    logic c;
    logic d;
  } ebpoc_pins_t;

endpackage

/* core/ebpoc_sync.sv */
// three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/1ps
`default_nettype none
module ebpoc_sync #(
  parameter logic INIT = 1'b0
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic d,
  output logic q
);
  logic s1;
  logic s2;
  logic s3;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s1 <= INIT;
      s2 <= INIT;
      s3 <= INIT;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // a change counts only once stages two and three agree
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q <= INIT;
    end else if (s2 == s3) begin
      q <= s3;
    end
  end
endmodule
`default_nettype wire

/* core/ebpoc_deadband.sv */
// rising-edge delay for one half-bridge output
`timescale 1ns/1ps
`default_nettype none
module ebpoc_deadband #(
  parameter int CW = ebpoc_pkg::DB_CNT_W,
  parameter int CLKS_PER_TCY = ebpoc_pkg::CLKS_PER_TCY
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic sig_in,
  input wire logic [6:0] delay_tcy,
  output logic sig_out
);
  logic [CW-1:0] cnt;
  logic [CW-1:0] target;

  assign target = CW'(delay_tcy) * CW'(CLKS_PER_TCY);

  // falling edges pass at once; a delay above the duty keeps it low
  always_ff @(posedge clk_sys) begin
    if (rst || !sig_in) begin
      cnt <= '0;
    end else if (cnt < target) begin
      cnt <= cnt + 1'b1;
    end
  end

  // gated by the input so turn-off never waits a cycle on the counter
  assign sig_out = sig_in && (cnt >= target);
endmodule
`default_nettype wire

/* core/ebpoc_top.sv */
// enhanced bridge output stage with shutdown, dead-band and steering
// Summary of operation
// - forward: A active, D modulated, B C off
// - reverse: C active, B modulated, A D off
// - direction from upper config bit, next cycle
// - last four counts: blank modulated, swap others
// - no dead-band in full-bridge mode
// - direction write accepted anywhere in cycle
// - source field enables pin-low, comparator-high triggers
// - shutdown status sets, stays until cleared
// - shutdown forces each pair to selected state
// - trigger is a level, holds shutdown
// - status writes ignored while trigger present
// - restart resumes only at next period
// - software shutdown; auto-restart clears it promptly
// - auto-restart clears status when trigger leaves
// - half-bridge delay only on rising transition
// - seven-bit delay in instruction cycles
// - single mode steers PWM to enabled pins
// - steered polarity from low mode bits
// - steering shutdown forces only steered pins
// - steering sync: immediate or next period
// - config: single, forward, half, reverse
//
// Implementation choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module ebpoc_top #(
  parameter int TW = 8,
  parameter int CLKS_PER_TCY = ebpoc_pkg::CLKS_PER_TCY
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic [TW-1:0] PERIOD_TIMER,
  input wire logic [TW-1:0] PERIOD_LIMIT,
  input wire logic PWM_RAW,
  input wire logic SHUTDOWN_PIN_N,
  input wire logic COMPARATOR_ONE_OUTPUT,
  input wire logic [3:0] PIN_DIRECTION_BITS,
  output logic BRIDGE_OUT_A,
  output logic BRIDGE_OUT_B,
  output logic BRIDGE_OUT_C,
  output logic BRIDGE_OUT_D,
  output logic BRIDGE_OUT_A_OE,
  output logic BRIDGE_OUT_B_OE,
  output logic BRIDGE_OUT_C_OE,
  output logic BRIDGE_OUT_D_OE
);
  ebpoc_pkg::ebpoc_cfg_t output_config_field;
  logic [3:0] unit_mode_select;
  logic shutdown_event_status;
  logic [2:0] shutdown_source_select;
  logic [1:0] pair_ac_shutdown_state;
  logic [1:0] pair_bd_shutdown_state;
  logic auto_restart_enable;
  logic [6:0] deadband_delay;
  logic steering_sync_select;
  logic [3:0] steering_enable_bits;
  logic [3:0] steer_eff;
  logic dir_eff;
  logic acc;
  logic wr_pend;
  logic rd_wait;
  logic [7:0] wr_addr;
  logic [7:0] rd_addr;
  logic [31:0] rd_word;
  logic wr_ctrl;
  logic wr_shdn;
  logic wr_dbnd;
  logic wr_steer;
  logic pin_low;
  logic cmp_high;
  logic trig;
  logic shut_now;
  logic eq;
  logic eq_q;
  logic period_start;
  logic [TW-1:0] lead_gap;
  logic lead;
  logic pwm_mode;
  logic full;
  logic changing;
  logic db_a;
  logic db_b;
  ebpoc_pkg::ebpoc_state_t state;
  ebpoc_pkg::ebpoc_state_t next_state;
  ebpoc_pkg::ebpoc_pins_t next_lvl;
  ebpoc_pkg::ebpoc_pins_t next_en;
  ebpoc_pkg::ebpoc_pins_t next_out;
  ebpoc_pkg::ebpoc_pins_t next_oe;
  ebpoc_pkg::ebpoc_pins_t lvl_q;
  ebpoc_pkg::ebpoc_pins_t out_q;
  ebpoc_pkg::ebpoc_pins_t oe_q;
  ebpoc_pkg::ebpoc_pins_t pin_direction_bits;

  // returns {oe, level} for one pin
  function automatic logic [1:0] pin_drive(
    input logic lvl, input logic en, input logic pol,
    input logic [1:0] safe, input logic dir_in,
    input ebpoc_pkg::ebpoc_state_t st);
    logic [1:0] r;
    r = 2'h0;
    if (en && !dir_in) begin
      if (st == ebpoc_pkg::ST_RUN) begin
        r = {1'b1, lvl ^ pol};
      end else if (st == ebpoc_pkg::ST_SHUT ||
                   st == ebpoc_pkg::ST_RESTART) begin
        r = {!safe[ebpoc_pkg::SAFE_TRI_BIT], safe[0]};
      end
    end
    return r;
  endfunction

  // AHB-Lite slave; reads take one wait state so that a read right
  // behind a write sees the written value
  assign acc = HSEL && HTRANS[1] && HREADY &&
               (HSIZE == ebpoc_pkg::HSIZE_WORD);
  assign HREADYOUT = !rd_wait;
  assign HRESP = 1'b0;

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      wr_pend <= 1'b0;
      rd_wait <= 1'b0;
      wr_addr <= 8'h00;
      rd_addr <= 8'h00;
    end else begin
      wr_pend <= acc && HWRITE;
      rd_wait <= acc && !HWRITE;
      if (acc) begin
        wr_addr <= HADDR[7:0];
        rd_addr <= HADDR[7:0];
      end
    end
  end

  assign wr_ctrl = wr_pend && (wr_addr == ebpoc_pkg::ADDR_CTRL);
  assign wr_shdn = wr_pend && (wr_addr == ebpoc_pkg::ADDR_SHDN);
  assign wr_dbnd = wr_pend && (wr_addr == ebpoc_pkg::ADDR_DBND);
  assign wr_steer = wr_pend && (wr_addr == ebpoc_pkg::ADDR_STEER);

  always_comb begin
    rd_word = 32'h0;
    case (rd_addr)
      ebpoc_pkg::ADDR_CTRL: begin
        rd_word = {24'h0, output_config_field, 2'h0, unit_mode_select};
      end
      ebpoc_pkg::ADDR_SHDN: begin
        rd_word = {24'h0, shutdown_event_status, shutdown_source_select,
                   pair_ac_shutdown_state, pair_bd_shutdown_state};
      end
      ebpoc_pkg::ADDR_DBND: begin
        rd_word = {24'h0, auto_restart_enable, deadband_delay};
      end
      ebpoc_pkg::ADDR_STEER: begin
        rd_word = {27'h0, steering_sync_select, steering_enable_bits};
      end
      ebpoc_pkg::ADDR_STAT: begin
        rd_word = {14'h0, steer_eff, state, dir_eff, trig, out_q, oe_q};
      end
      default: begin
        rd_word = 32'h0;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      HRDATA <= 32'h0;
    end else if (rd_wait) begin
      HRDATA <= rd_word;
    end
  end

  // configuration; a direction write lands at any point of the cycle
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      output_config_field <= ebpoc_pkg::CFG_SINGLE;
      unit_mode_select <= ebpoc_pkg::MODE_RST;
    end else if (wr_ctrl) begin
      output_config_field <= ebpoc_pkg::ebpoc_cfg_t'(
        HWDATA[ebpoc_pkg::CTRL_CFG_LSB +: 2]);
      unit_mode_select <= HWDATA[ebpoc_pkg::CTRL_MODE_LSB +: 4];
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      shutdown_source_select <= ebpoc_pkg::SRC_RST;
      pair_ac_shutdown_state <= ebpoc_pkg::SAFE_RST;
      pair_bd_shutdown_state <= ebpoc_pkg::SAFE_RST;
    end else if (wr_shdn) begin
      shutdown_source_select <= HWDATA[ebpoc_pkg::SHDN_SRC_LSB +: 3];
      pair_ac_shutdown_state <= HWDATA[ebpoc_pkg::SHDN_AC_LSB +: 2];
      pair_bd_shutdown_state <= HWDATA[ebpoc_pkg::SHDN_BD_LSB +: 2];
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      auto_restart_enable <= 1'b0;
      deadband_delay <= ebpoc_pkg::DLY_RST;
    end else if (wr_dbnd) begin
      auto_restart_enable <= HWDATA[ebpoc_pkg::DBND_AUTO_BIT];
      deadband_delay <= HWDATA[ebpoc_pkg::DBND_DLY_LSB +: 7];
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      steering_sync_select <= 1'b0;
      steering_enable_bits <= ebpoc_pkg::STEER_RST;
    end else if (wr_steer) begin
      steering_sync_select <= HWDATA[ebpoc_pkg::STEER_SYNC_BIT];
      steering_enable_bits <= HWDATA[ebpoc_pkg::STEER_EN_LSB +: 4];
    end
  end

  // shutdown sources arrive from pins and are synchronised
  ebpoc_sync #(.INIT(1'b1)) u_pin_sync (
    .clk_sys(CLK_SYS),
    .rst(RST),
    .d(SHUTDOWN_PIN_N),
    .q(pin_low)
  );

  ebpoc_sync #(.INIT(1'b0)) u_cmp_sync (
    .clk_sys(CLK_SYS),
    .rst(RST),
    .d(COMPARATOR_ONE_OUTPUT),
    .q(cmp_high)
  );

  assign trig =
    (shutdown_source_select[ebpoc_pkg::SRC_INT_BIT] && !pin_low) ||
    (shutdown_source_select[ebpoc_pkg::SRC_CMP_BIT] && cmp_high);
  assign shut_now = shutdown_event_status || trig;

  // trigger beats any write; a software set is visible for one cycle
  // before auto-restart removes it
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      shutdown_event_status <= 1'b0;
    end else if (trig) begin
      shutdown_event_status <= 1'b1;
    end else if (wr_shdn) begin
      shutdown_event_status <= HWDATA[ebpoc_pkg::SHDN_STATUS_BIT];
    end else if (auto_restart_enable) begin
      shutdown_event_status <= 1'b0;
    end
  end

  // period boundary from the shared timer
  assign eq = (PERIOD_TIMER == PERIOD_LIMIT);
  assign period_start = eq_q && !eq;
  assign lead_gap = PERIOD_LIMIT - PERIOD_TIMER;
  assign lead = (PERIOD_TIMER <= PERIOD_LIMIT) &&
                (lead_gap < TW'(ebpoc_pkg::DIR_LEAD_COUNTS));

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      eq_q <= 1'b0;
    end else begin
      eq_q <= eq;
    end
  end

  assign pwm_mode = (unit_mode_select[3:2] == ebpoc_pkg::MODE_PWM);
  assign full = pwm_mode &&
                (output_config_field == ebpoc_pkg::CFG_FWD ||
                 output_config_field == ebpoc_pkg::CFG_REV);
  assign changing = full && (output_config_field[1] != dir_eff);

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      dir_eff <= 1'b0;
    end else if (eq) begin
      // taken in the last count so the new period opens turned
      dir_eff <= output_config_field[1];
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      steer_eff <= ebpoc_pkg::STEER_RST;
    end else if (!steering_sync_select || period_start) begin
      steer_eff <= steering_enable_bits;
    end
  end

  ebpoc_deadband #(
    .CW(ebpoc_pkg::DB_CNT_W),
    .CLKS_PER_TCY(CLKS_PER_TCY)
  ) u_db_a (
    .clk_sys(CLK_SYS),
    .rst(RST),
    .sig_in(PWM_RAW),
    .delay_tcy(deadband_delay),
    .sig_out(db_a)
  );

  ebpoc_deadband #(
    .CW(ebpoc_pkg::DB_CNT_W),
    .CLKS_PER_TCY(CLKS_PER_TCY)
  ) u_db_b (
    .clk_sys(CLK_SYS),
    .rst(RST),
    .sig_in(!PWM_RAW),
    .delay_tcy(deadband_delay),
    .sig_out(db_b)
  );

  // output starts only at a period boundary, never mid-waveform
  always_comb begin
    next_state = state;
    case (state)
      ebpoc_pkg::ST_OFF: begin
        if (pwm_mode && shut_now) begin
          next_state = ebpoc_pkg::ST_SHUT;
        end else if (pwm_mode && period_start) begin
          next_state = ebpoc_pkg::ST_RUN;
        end
      end
      ebpoc_pkg::ST_RUN: begin
        if (shut_now) begin
          next_state = ebpoc_pkg::ST_SHUT;
        end
      end
      ebpoc_pkg::ST_SHUT: begin
        if (!shut_now) begin
          next_state = ebpoc_pkg::ST_RESTART;
        end
      end
      ebpoc_pkg::ST_RESTART: begin
        if (shut_now) begin
          next_state = ebpoc_pkg::ST_SHUT;
        end else if (period_start) begin
          next_state = ebpoc_pkg::ST_RUN;
        end
      end
      default: begin
        next_state = ebpoc_pkg::ST_OFF;
      end
    endcase
    if (!pwm_mode) begin
      next_state = ebpoc_pkg::ST_OFF;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      state <= ebpoc_pkg::ST_OFF;
    end else begin
      state <= next_state;
    end
  end

  // logical (active-high) pin levels and which pins the unit owns
  always_comb begin
    next_lvl = '0;
    next_en = '0;
    if (pwm_mode) begin
      case (output_config_field)
        ebpoc_pkg::CFG_SINGLE: begin
          next_lvl = {4{PWM_RAW}};
          next_en = {steer_eff[0], steer_eff[1],
                     steer_eff[2], steer_eff[3]};
        end
        ebpoc_pkg::CFG_HALF: begin
          next_lvl.a = db_a;
          next_lvl.b = db_b;
          next_en.a = 1'b1;
          next_en.b = 1'b1;
        end
        default: begin
          next_en = '1;
          // swap early in the lead window, modulation blanked till wrap
          if ((changing && lead) ? output_config_field[1] : dir_eff) begin
            next_lvl.c = 1'b1;
            next_lvl.b = PWM_RAW && !(changing && lead);
          end else begin
            next_lvl.a = 1'b1;
            next_lvl.d = PWM_RAW && !(changing && lead);
          end
        end
      endcase
    end
  end

  // pin direction bits low let the driver through
  assign pin_direction_bits = {PIN_DIRECTION_BITS[0], PIN_DIRECTION_BITS[1],
                 PIN_DIRECTION_BITS[2], PIN_DIRECTION_BITS[3]};

  always_comb begin
    {next_oe.a, next_out.a} = pin_drive(next_lvl.a, next_en.a,
      unit_mode_select[1], pair_ac_shutdown_state, pin_direction_bits.a,
      next_state);
    {next_oe.c, next_out.c} = pin_drive(next_lvl.c, next_en.c,
      unit_mode_select[1], pair_ac_shutdown_state, pin_direction_bits.c,
      next_state);
    {next_oe.b, next_out.b} = pin_drive(next_lvl.b, next_en.b,
      unit_mode_select[0], pair_bd_shutdown_state, pin_direction_bits.b,
      next_state);
    {next_oe.d, next_out.d} = pin_drive(next_lvl.d, next_en.d,
      unit_mode_select[0], pair_bd_shutdown_state, pin_direction_bits.d,
      next_state);
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      lvl_q <= '0;
      out_q <= '0;
      oe_q <= '0;
    end else begin
      lvl_q <= next_lvl;
      out_q <= next_out;
      oe_q <= next_oe;
    end
  end

  assign BRIDGE_OUT_A = out_q.a;
  assign BRIDGE_OUT_B = out_q.b;
  assign BRIDGE_OUT_C = out_q.c;
  assign BRIDGE_OUT_D = out_q.d;
  assign BRIDGE_OUT_A_OE = oe_q.a;
  assign BRIDGE_OUT_B_OE = oe_q.b;
  assign BRIDGE_OUT_C_OE = oe_q.c;
  assign BRIDGE_OUT_D_OE = oe_q.d;

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  sequence steady_full_s;
    full && !changing && !shut_now;
  endsequence

  sequence dir_change_s;
    changing && lead;
  endsequence

  fwd_drive_a: assert property (
    steady_full_s and !dir_eff |=> lvl_q.a && !lvl_q.b && !lvl_q.c)
    else $error("forward bridge levels wrong");

  rev_drive_a: assert property (
    steady_full_s and dir_eff |=> lvl_q.c && !lvl_q.a && !lvl_q.d)
    else $error("reverse bridge levels wrong");

  dir_blank_a: assert property (
    dir_change_s |=> !lvl_q.b && !lvl_q.d && (lvl_q.c != lvl_q.a))
    else $error("modulated output not blanked on turn");

  dir_commit_a: assert property (
    eq && full |=> dir_eff == $past(output_config_field[1]))
    else $error("direction not taken at period start");

  full_nodelay_a: assert property (
    steady_full_s and !dir_eff |=> lvl_q.d == $past(PWM_RAW))
    else $error("full-bridge output delayed");

  sd_set_a: assert property (
    trig |=> shutdown_event_status ##1
      (shutdown_event_status || !$past(trig)))
    else $error("status not set by trigger");

  sd_hold_a: assert property (
    trig && wr_shdn |=> shutdown_event_status)
    else $error("status write accepted during trigger");

  sd_force_a: assert property (
    pwm_mode && shut_now |=> state == ebpoc_pkg::ST_SHUT)
    else $error("outputs not shut while trigger present");

  restart_wait_a: assert property (
    state == ebpoc_pkg::ST_RESTART && !period_start && !shut_now &&
    pwm_mode |=> state == ebpoc_pkg::ST_RESTART)
    else $error("output resumed before period start");

  auto_clear_a: assert property (
    auto_restart_enable && !trig && !wr_shdn |=> !shutdown_event_status)
    else $error("auto restart did not clear status");

  steer_now_a: assert property (
    !steering_sync_select |=> steer_eff == $past(steering_enable_bits))
    else $error("immediate steering not applied");

  half_rise_a: assert property (
    pwm_mode && output_config_field == ebpoc_pkg::CFG_HALF &&
    deadband_delay != 7'h00 && $rose(PWM_RAW) |=> !lvl_q.a)
    else $error("half-bridge rise not delayed");
endmodule
`default_nettype wire

/* sim/ebpoc_bridge_model.sv */
// partner model: period timer, duty compare and bridge pins with pull-downs
`timescale 1ns/1ps
`default_nettype none
module ebpoc_bridge_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] limit,
  input wire logic [7:0] duty,
  input wire ebpoc_pkg::ebpoc_pins_t out,
  input wire ebpoc_pkg::ebpoc_pins_t oe,
  output logic [7:0] timer,
  output logic pwm,
  output ebpoc_pkg::ebpoc_pins_t lvl
);
  always_ff @(posedge clk) begin
    if (rst || timer == limit) begin
      timer <= 8'h00;
    end else begin
      timer <= timer + 8'h01;
    end
  end
  // duty above the limit keeps the signal high for the whole period
  assign pwm = timer < duty;
  // a released pin falls to its pull-down, never keeps the last level
  assign lvl = ebpoc_pkg::ebpoc_pins_t'(out & oe);
endmodule
`default_nettype wire

/* sim/tb_enhanced_pwm_bridge_output_control.sv */
// testbench of the enhanced bridge output stage
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("unexpected at %0t: got %h exp %h", $time, (g), (e)); end end
module tb_enhanced_pwm_bridge_output_control;
  logic clk_sys, rst, hsel, hwrite, rdy_h, pin_n, cmp, hreadyout;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans;
  logic [7:0] duty;
  logic [3:0] pdir;
  wire logic [7:0] timer;
  wire logic [7:0] pv;
  wire logic pwm, hresp;
  wire ebpoc_pkg::ebpoc_pins_t out, oe, lvl;
  int error_cnt, checked;
  assign pv = {lvl, oe};
  ebpoc_top #(.TW(8), .CLKS_PER_TCY(4)) dut_u (
    .CLK_SYS(clk_sys), .RST(rst), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(ebpoc_pkg::HSIZE_WORD),
    .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .PERIOD_TIMER(timer),
    .PERIOD_LIMIT(8'h0f), .PWM_RAW(pwm), .SHUTDOWN_PIN_N(pin_n),
    .COMPARATOR_ONE_OUTPUT(cmp),
    .PIN_DIRECTION_BITS(pdir),
    .BRIDGE_OUT_A(out.a), .BRIDGE_OUT_B(out.b), .BRIDGE_OUT_C(out.c),
    .BRIDGE_OUT_D(out.d), .BRIDGE_OUT_A_OE(oe.a), .BRIDGE_OUT_B_OE(oe.b),
    .BRIDGE_OUT_C_OE(oe.c), .BRIDGE_OUT_D_OE(oe.d));
  ebpoc_bridge_model part_u (.clk(clk_sys), .rst(rst), .limit(8'h0f),
    .duty(duty), .out(out), .oe(oe), .timer(timer), .pwm(pwm), .lvl(lvl));
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // mid-cycle copy avoids racing the slave's own edge update
  always @(negedge clk_sys) rdy_h <= hreadyout;
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge clk_sys);
    hsel <= 1'b1; haddr <= {24'h0, a}; htrans <= 2'h2; hwrite <= w;
    do @(posedge clk_sys); while (rdy_h !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
    do @(posedge clk_sys); while (rdy_h !== 1'b1);
    q = hrdata;
  endtask
  task automatic at(input logic [7:0] v);
    do @(negedge clk_sys); while (timer !== v);
  endtask
  task automatic t_reset;
    `CHK(pv, 8'h00);
    bus(1'b1, 8'h20, 32'hff);
    bus(1'b0, 8'h20, 32'h0);
    `CHK(q, 32'h0);
    bus(1'b0, ebpoc_pkg::ADDR_CTRL, 32'h0);
    `CHK(q, 32'h0);
    bus(1'b0, ebpoc_pkg::ADDR_STEER, 32'h0);
    `CHK(q, 32'h1);
    bus(1'b0, ebpoc_pkg::ADDR_SHDN, 32'h0);
    `CHK(q, 32'h0);
    `CHK(hresp, 1'b0);
  endtask
  task automatic t_fwd;
    @(posedge clk_sys) duty <= 8'd8;
    bus(1'b1, ebpoc_pkg::ADDR_DBND, 32'h7f);
    bus(1'b1, ebpoc_pkg::ADDR_CTRL, 32'h4c);
    at(8'd0);
    at(8'd2);
    `CHK(pv, 8'h9f);
    at(8'd12);
    `CHK(pv, 8'h8f);
  endtask
  task automatic t_dir;
    @(posedge clk_sys) duty <= 8'd16;
    at(8'd3);
    bus(1'b1, ebpoc_pkg::ADDR_CTRL, 32'hcc);
    at(8'd10);
    `CHK(pv, 8'h9f);
    at(8'd15);
    `CHK(pv, 8'h2f);
    at(8'd1);
    `CHK(pv, 8'h6f);
    at(8'd2);
    `CHK(pv, 8'h6f);
  endtask
  task automatic t_half;
    @(posedge clk_sys) duty <= 8'd8;
    bus(1'b1, ebpoc_pkg::ADDR_DBND, 32'h01);
    bus(1'b1, ebpoc_pkg::ADDR_CTRL, 32'h8c);
    at(8'd0);
    at(8'd3);
    `CHK(pv[7:6], 2'b00);
    at(8'd4);
    `CHK(pv[7:6], 2'b00);
    at(8'd5);
    `CHK(pv[7:6], 2'b10);
    at(8'd8);
    `CHK(pv[7:6], 2'b10);
    at(8'd10);
    `CHK(pv[7:6], 2'b00);
    at(8'd15);
    `CHK(pv[7:6], 2'b01);
  endtask
  task automatic t_shut;
    @(posedge clk_sys) duty <= 8'd16;
    bus(1'b1, ebpoc_pkg::ADDR_CTRL, 32'h4c);
    bus(1'b1, ebpoc_pkg::ADDR_SHDN, 32'h16);
    @(posedge clk_sys) pin_n <= 1'b0;
    repeat (10) @(posedge clk_sys);
    @(negedge clk_sys);
    `CHK(pv, 8'haa);
    bus(1'b1, ebpoc_pkg::ADDR_SHDN, 32'h16);
    bus(1'b0, ebpoc_pkg::ADDR_SHDN, 32'h0);
    `CHK(q, 32'h96);
    @(posedge clk_sys) pin_n <= 1'b1;
    repeat (10) @(posedge clk_sys);
    bus(1'b0, ebpoc_pkg::ADDR_SHDN, 32'h0);
    `CHK(q, 32'h96);
    `CHK(pv, 8'haa);
    bus(1'b1, ebpoc_pkg::ADDR_SHDN, 32'h16);
    bus(1'b0, ebpoc_pkg::ADDR_SHDN, 32'h0);
    `CHK(q, 32'h16);
    at(8'd0);
    at(8'd2);
    `CHK(pv, 8'h9f);
  endtask
  task automatic t_auto;
    bus(1'b1, ebpoc_pkg::ADDR_DBND, 32'h80);
    bus(1'b1, ebpoc_pkg::ADDR_SHDN, 32'ha0);
    bus(1'b0, ebpoc_pkg::ADDR_SHDN, 32'h0);
    `CHK(q, 32'h20);
    @(posedge clk_sys) cmp <= 1'b1;
    repeat (10) @(posedge clk_sys);
    bus(1'b0, ebpoc_pkg::ADDR_SHDN, 32'h0);
    `CHK(q, 32'ha0);
    `CHK(pv, 8'h0f);
    @(posedge clk_sys) cmp <= 1'b0;
    repeat (10) @(posedge clk_sys);
    bus(1'b0, ebpoc_pkg::ADDR_SHDN, 32'h0);
    `CHK(q, 32'h20);
    at(8'd0);
    at(8'd2);
    `CHK(pv, 8'h9f);
    @(posedge clk_sys) pdir <= 4'h9;
    at(8'd4);
    `CHK(pv, 8'h06);
    @(posedge clk_sys) pdir <= 4'h0;
  endtask
  task automatic t_steer;
    @(posedge clk_sys) duty <= 8'd0;
    bus(1'b1, ebpoc_pkg::ADDR_CTRL, 32'h0f);
    bus(1'b1, ebpoc_pkg::ADDR_STEER, 32'h05);
    at(8'd3);
    `CHK(pv, 8'haa);
    bus(1'b1, ebpoc_pkg::ADDR_STEER, 32'h1a);
    @(negedge clk_sys);
    `CHK(pv, 8'haa);
    at(8'd0);
    at(8'd2);
    `CHK(pv, 8'h55);
    bus(1'b1, ebpoc_pkg::ADDR_SHDN, 32'h10);
    @(posedge clk_sys) pin_n <= 1'b0;
    repeat (10) @(posedge clk_sys);
    @(negedge clk_sys);
    `CHK(pv, 8'h05);
    @(posedge clk_sys) pin_n <= 1'b1;
  endtask
  task automatic wrap_up;
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    rst = 1'b1; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
    hwdata = 32'h0; duty = 8'h0; pin_n = 1'b1; cmp = 1'b0; pdir = 4'h0;
    error_cnt = 0; checked = 0;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset;
    t_fwd;
    t_dir;
    t_half;
    t_shut;
    t_auto;
    t_steer;
    wrap_up;
  end
  // whole run is a few hundred cycles; this is many times that
  initial begin
    #100000;
    error_cnt++;
    wrap_up;
  end
endmodule
`default_nettype wire
